//--- src/wg_pkg.sv
// shared constants and types for the pin waveform timing block
package wg_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [15:0] ADDR_PIN1_FOURTH = 16'h1086;
  localparam logic [15:0] ADDR_PIN0_FOURTH = 16'h1087;
  localparam logic [15:0] ADDR_PIN1_FIFTH = 16'h1088;
  localparam logic [15:0] ADDR_PIN0_FIFTH = 16'h1089;
  localparam logic [15:0] ADDR_PIN1_COUNT = 16'h108a;
  localparam logic [15:0] ADDR_PIN0_COUNT = 16'h108b;
  localparam logic [15:0] ADDR_PIN3_FIRST = 16'h108c;
  localparam logic [15:0] ADDR_PIN2_FIRST = 16'h108d;
  localparam logic [15:0] ADDR_PIN3_SECOND = 16'h108e;
  localparam logic [15:0] ADDR_PIN2_SECOND = 16'h108f;
  localparam logic [15:0] REG_BASE = ADDR_PIN1_FOURTH;
  localparam logic [15:0] REG_LAST = ADDR_PIN2_SECOND;
  localparam int NUM_REGS = 10;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // register indices derived from the offsets
  localparam logic [3:0] IDX_PIN1_FOURTH = 4'(ADDR_PIN1_FOURTH - REG_BASE);
  localparam logic [3:0] IDX_PIN0_FOURTH = 4'(ADDR_PIN0_FOURTH - REG_BASE);
  localparam logic [3:0] IDX_PIN1_FIFTH = 4'(ADDR_PIN1_FIFTH - REG_BASE);
  localparam logic [3:0] IDX_PIN0_FIFTH = 4'(ADDR_PIN0_FIFTH - REG_BASE);
  localparam logic [3:0] IDX_PIN1_COUNT = 4'(ADDR_PIN1_COUNT - REG_BASE);
  localparam logic [3:0] IDX_PIN0_COUNT = 4'(ADDR_PIN0_COUNT - REG_BASE);
  localparam logic [3:0] IDX_PIN3_FIRST = 4'(ADDR_PIN3_FIRST - REG_BASE);
  localparam logic [3:0] IDX_PIN2_FIRST = 4'(ADDR_PIN2_FIRST - REG_BASE);
  localparam logic [3:0] IDX_PIN3_SECOND = 4'(ADDR_PIN3_SECOND - REG_BASE);
  localparam logic [3:0] IDX_PIN2_SECOND = 4'(ADDR_PIN2_SECOND - REG_BASE);

  // ==========================================================================
  // waveform shape and timing
  // ==========================================================================
  localparam int NUM_PINS = 4;
  localparam int NUM_SUBS = 5;
  localparam logic [2:0] FIRST_SUB = 3'h0;
  localparam logic [2:0] LAST_SUB = 3'h4;
  localparam logic [4:0] HIGH_SUBS = 5'h15; // pin high in subperiods 0,2,4
  localparam logic [15:0] ONE_PERIOD = 16'h0001;
  localparam logic [15:0] INFINITE_COUNT = 16'h0000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS = 50; // one subperiod unit
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef logic [NUM_SUBS-1:0][15:0] sub_times_t;

  typedef enum logic [0:0] {
    CH_IDLE = 1'b0,
    CH_RUN = 1'b1
  } chan_state_t;

endpackage : wg_pkg

//--- src/wg_channel.sv
// one waveform sequencer: five subperiods per period, counted periods
`timescale 1ns/1ps
module wg_channel
  import wg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic start,
  input wire logic stop,
  input wire logic [15:0] count_in,
  input wire sub_times_t times,
  output logic level,
  output logic [15:0] remaining
);

  chan_state_t state_reg, state_next;
  logic [2:0] sub_reg, sub_next;
  logic [15:0] timer_reg, timer_next;
  logic [15:0] remaining_reg, remaining_next;
  logic infinite_reg, infinite_next;

  // ==========================================================================
  // sequencing terms
  // ==========================================================================
  wire logic running = (state_reg == CH_RUN);
  wire logic sub_end = running && tick && (timer_reg >= times[sub_reg]);
  wire logic period_end = sub_end && (sub_reg == LAST_SUB);
  wire logic last_period = period_end && !infinite_reg &&
                           (remaining_reg == ONE_PERIOD);

  // next state: start reloads, stop halts, final period halts
  always_comb begin
    state_next = state_reg;
    sub_next = sub_reg;
    timer_next = timer_reg;
    remaining_next = remaining_reg;
    infinite_next = infinite_reg;
    if (stop) begin
      state_next = CH_IDLE;
    end else if (start) begin
      state_next = CH_RUN;
      sub_next = FIRST_SUB;
      timer_next = 16'h0000;
      remaining_next = count_in;
      infinite_next = (count_in == INFINITE_COUNT);
    end else if (sub_end) begin
      timer_next = 16'h0000;
      sub_next = period_end ? FIRST_SUB : 3'(sub_reg + 3'h1);
      if (period_end && !infinite_reg) begin
        remaining_next = 16'(remaining_reg - ONE_PERIOD);
      end
      if (last_period) begin
        state_next = CH_IDLE;
      end
    end else if (running && tick) begin
      timer_next = 16'(timer_reg + 16'h0001);
    end
  end

  // state registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state_reg <= CH_IDLE;
      sub_reg <= FIRST_SUB;
      timer_reg <= 16'h0000;
      remaining_reg <= 16'h0000;
      infinite_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      sub_reg <= sub_next;
      timer_reg <= timer_next;
      remaining_reg <= remaining_next;
      infinite_reg <= infinite_next;
    end
  end

  assign level = running && HIGH_SUBS[sub_reg];
  assign remaining = remaining_reg;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  count_load_a: assert property (start && !stop |=>
    remaining_reg == $past(count_in) && running)
    else $error("period count not loaded");
  endless_hold_a: assert property (infinite_reg && running && !start |=>
    remaining_reg == $past(remaining_reg))
    else $error("endless waveform changed its count");
  period_dec_a: assert property (period_end && !infinite_reg && !start &&
    !stop |=> remaining_reg == $past(remaining_reg) - 16'h0001)
    else $error("remaining count not decremented");
  finite_stop_a: assert property (last_period && !start |=>
    !running && !level && remaining_reg == 16'h0000)
    else $error("finite waveform did not stop");

endmodule : wg_channel

//--- src/wg_timing_regs.sv
// waveform timing registers and period counters for pins 0 to 3
// Notes on behaviour
// - pin1 fourth reg; 16-bit: pin0 fourth high byte
// - pin0 fourth reg; 16-bit: its low byte
// - pin1 fifth reg; 16-bit: pin0 fifth high byte
// - pin0 fifth reg; 16-bit: its low byte
// - count write sets periods before stop
// - zero count runs the waveform forever
// - count read returns periods still remaining
// - upper byte read first keeps 16-bit coherent
// - pin1 count is pin0 duration high byte in 16-bit mode
// - pin3/pin2 first subperiods, combined in 16-bit
// - pin3/pin2 second subperiods, combined in 16-bit
// - pin2 first reg alone in 8-bit mode
`timescale 1ns/1ps
module wg_timing_regs
  import wg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire reg_req_t bus_req,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] mode_16bit,
  input wire logic [2:0][1:0][7:0] pair01_early_sub,
  input wire logic [2:0][1:0][7:0] pair23_late_sub,
  input wire logic [1:0][7:0] pair23_count,
  input wire logic pair23_load,
  output logic [3:0] waveform_pin
);

  // ==========================================================================
  // register decode
  // ==========================================================================
  logic [7:0] regs_reg [NUM_REGS];
  logic [7:0] rdata_reg, rdata_next;
  logic [7:0] snap_reg, snap_next;
  logic snap_valid_reg, snap_valid_next;
  logic [3:0] pin_reg;
  logic [1:0] mode_prev_reg;
  logic [7:0] tick_cnt_reg;
  logic tick_reg;

  // address hit and register index
  wire logic addr_hit = (bus_req.addr >= REG_BASE) &&
                        (bus_req.addr <= REG_LAST);
  wire logic [15:0] addr_off = 16'(bus_req.addr - REG_BASE);
  wire logic [3:0] reg_idx = addr_off[3:0];
  wire logic wr_hit = bus_req.wr && addr_hit;
  wire logic rd_hit = bus_req.rd && addr_hit;

  // strobes for the two period count registers
  wire logic wr_pin0_count = wr_hit && (reg_idx == IDX_PIN0_COUNT);
  wire logic wr_pin1_count = wr_hit && (reg_idx == IDX_PIN1_COUNT);
  wire logic rd_pin0_count = rd_hit && (reg_idx == IDX_PIN0_COUNT);
  wire logic rd_pin1_count = rd_hit && (reg_idx == IDX_PIN1_COUNT);

  // ==========================================================================
  // register storage
  // ==========================================================================
  // one byte register per entry, written when the index matches
  genvar r;
  generate
    for (r = 0; r < NUM_REGS; r++) begin : g_regs
      always_ff @(posedge sys_clk) begin
        if (!nrst) begin
          regs_reg[r] <= REG_RESET;
        end else if (wr_hit && (reg_idx == 4'(r))) begin
          regs_reg[r] <= bus_req.wdata;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // subperiod byte matrix, per pin and subperiod
  // ==========================================================================
  logic [7:0] sub_byte [NUM_PINS][NUM_SUBS];

  // pins 0/1 early and pins 2/3 late subperiods come from neighbouring logic
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_early
      assign sub_byte[0][k] = pair01_early_sub[k][0];
      assign sub_byte[1][k] = pair01_early_sub[k][1];
      assign sub_byte[2][k+2] = pair23_late_sub[k][0];
      assign sub_byte[3][k+2] = pair23_late_sub[k][1];
    end
  endgenerate

  // pins 0/1: fourth and fifth subperiods from this register set
  assign sub_byte[1][3] = regs_reg[IDX_PIN1_FOURTH];
  assign sub_byte[0][3] = regs_reg[IDX_PIN0_FOURTH];
  assign sub_byte[1][4] = regs_reg[IDX_PIN1_FIFTH];
  assign sub_byte[0][4] = regs_reg[IDX_PIN0_FIFTH];

  // pins 2/3: first and second subperiods from this register set
  assign sub_byte[3][0] = regs_reg[IDX_PIN3_FIRST];
  assign sub_byte[2][0] = regs_reg[IDX_PIN2_FIRST];
  assign sub_byte[3][1] = regs_reg[IDX_PIN3_SECOND];
  assign sub_byte[2][1] = regs_reg[IDX_PIN2_SECOND];

  // ==========================================================================
  // subperiod unit divider
  // ==========================================================================
  // one-cycle tick every TICK_CYCLES clocks
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tick_cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= (tick_cnt_reg == TICK_LAST) ? 8'h00 :
                      8'(tick_cnt_reg + 8'h01);
      tick_reg <= (tick_cnt_reg == TICK_LAST);
    end
  end

  // ==========================================================================
  // channel controls
  // ==========================================================================
  sub_times_t chan_times [NUM_PINS];
  logic [15:0] chan_count [NUM_PINS];
  logic [15:0] chan_rem [NUM_PINS];
  logic [NUM_PINS-1:0] chan_start;
  logic [NUM_PINS-1:0] chan_stop;
  logic [NUM_PINS-1:0] chan_level;
  wire logic [1:0] mode_change = mode_16bit ^ mode_prev_reg;

  // remember the pair modes so a change halts both channels
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      mode_prev_reg <= 2'h0;
    end else begin
      mode_prev_reg <= mode_16bit;
    end
  end

  // period count loads; pin0 16-bit loads on the low byte write, pin2 16-bit on pair23_load
  assign chan_count[0] = mode_16bit[0] ?
    {regs_reg[IDX_PIN1_COUNT], bus_req.wdata} :
    {8'h00, bus_req.wdata};
  assign chan_count[1] = {8'h00, bus_req.wdata};
  assign chan_count[2] = mode_16bit[1] ?
    {pair23_count[1], pair23_count[0]} : {8'h00, pair23_count[0]};
  assign chan_count[3] = {8'h00, pair23_count[1]};
  assign chan_start[0] = wr_pin0_count;
  assign chan_start[1] = wr_pin1_count && !mode_16bit[0];
  assign chan_start[2] = pair23_load;
  assign chan_start[3] = pair23_load && !mode_16bit[1];

  // per pin: assemble times, halt odd pin in 16-bit mode
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pins
      for (k = 0; k < NUM_SUBS; k++) begin : g_sub
        if (p % 2 == 0) begin : g_even
          assign chan_times[p][k] = mode_16bit[p/2] ?
            {sub_byte[p+1][k], sub_byte[p][k]} :
            {8'h00, sub_byte[p][k]};
        end else begin : g_odd
          assign chan_times[p][k] = {8'h00, sub_byte[p][k]};
        end
      end
      if (p % 2 == 0) begin : g_stop_even
        assign chan_stop[p] = mode_change[p/2];
      end else begin : g_stop_odd
        assign chan_stop[p] = mode_change[p/2] || mode_16bit[p/2];
      end

      wg_channel u_chan (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .tick(tick_reg),
        .start(chan_start[p]),
        .stop(chan_stop[p]),
        .count_in(chan_count[p]),
        .times(chan_times[p]),
        .level(chan_level[p]),
        .remaining(chan_rem[p])
      );
    end
  endgenerate

  // ==========================================================================
  // read path
  // ==========================================================================
  // count registers show what is left; others show the stored byte
  wire logic [7:0] rem1_byte = mode_16bit[0] ? chan_rem[0][15:8] :
                               chan_rem[1][7:0];
  wire logic [7:0] rem0_byte = (mode_16bit[0] && snap_valid_reg) ?
                               snap_reg : chan_rem[0][7:0];
  wire logic [7:0] store_byte = regs_reg[reg_idx];
  wire logic [7:0] read_byte =
    !addr_hit ? UNMAPPED_READ :
    (reg_idx == IDX_PIN1_COUNT) ? rem1_byte :
    (reg_idx == IDX_PIN0_COUNT) ? rem0_byte : store_byte;

  // upper byte read freezes the lower byte until it is read
  assign snap_next = (rd_pin1_count && mode_16bit[0]) ?
                     chan_rem[0][7:0] : snap_reg;
  assign snap_valid_next =
    (rd_pin1_count && mode_16bit[0]) ? 1'b1 :
    (rd_pin0_count || !mode_16bit[0]) ? 1'b0 : snap_valid_reg;
  assign rdata_next = bus_req.rd ? read_byte : rdata_reg;

  // read data, snapshot and pin output registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
      snap_reg <= 8'h00;
      snap_valid_reg <= 1'b0;
      pin_reg <= 4'h0;
    end else begin
      rdata_reg <= rdata_next;
      snap_reg <= snap_next;
      snap_valid_reg <= snap_valid_next;
      pin_reg <= chan_level;
    end
  end

  assign reg_rdata = rdata_reg;
  assign waveform_pin = pin_reg;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  fourth_high_a: assert property (mode_16bit[0] |->
    chan_times[0][3][15:8] == regs_reg[IDX_PIN1_FOURTH])
    else $error("pin0 fourth subperiod high byte wrong");
  fourth_low_a: assert property (
    chan_times[0][3][7:0] == regs_reg[IDX_PIN0_FOURTH])
    else $error("pin0 fourth subperiod low byte wrong");
  fifth_high_a: assert property (
    (mode_16bit[0] ? chan_times[0][4][15:8] : chan_times[1][4][7:0])
    == regs_reg[IDX_PIN1_FIFTH])
    else $error("pin1 fifth subperiod byte wrong");
  fifth_low_a: assert property (
    chan_times[0][4][7:0] == regs_reg[IDX_PIN0_FIFTH])
    else $error("pin0 fifth subperiod low byte wrong");
  pair23_first_a: assert property (mode_16bit[1] |->
    chan_times[2][0] == {regs_reg[IDX_PIN3_FIRST],
    regs_reg[IDX_PIN2_FIRST]})
    else $error("pin2 first subperiod not combined");
  pair23_second_a: assert property (!mode_16bit[1] |->
    chan_times[3][1][7:0] == regs_reg[IDX_PIN3_SECOND] &&
    chan_times[2][1][7:0] == regs_reg[IDX_PIN2_SECOND])
    else $error("second subperiods of pins 2/3 wrong");
  pin2_alone_a: assert property (!mode_16bit[1] |->
    chan_times[2][0] == {8'h00, regs_reg[IDX_PIN2_FIRST]})
    else $error("pin2 first subperiod not standalone");

  // a 16-bit load takes the staged upper byte as bits 15:8
  count_high_a: assert property (wr_pin0_count && mode_16bit[0] |=>
    chan_rem[0][15:8] == $past(regs_reg[IDX_PIN1_COUNT]))
    else $error("pin1 count not used as high byte");

  // count read in 8-bit mode answers the remaining count next cycle
  count_read_a: assert property (rd_pin1_count && !mode_16bit[0] |=>
    reg_rdata == $past(chan_rem[1][7:0]))
    else $error("count read did not show remaining periods");

  // upper read, one idle cycle, lower read: low byte as at the upper read
  sequence upper_read_s;
    rd_pin1_count && mode_16bit[0];
  endsequence
  sequence lower_read_s;
    (!rd_hit && mode_16bit[0]) ##1 (rd_pin0_count && mode_16bit[0]);
  endsequence
  coherent_read_a: assert property (upper_read_s ##1 lower_read_s |=>
    reg_rdata == $past(chan_rem[0][7:0], 3))
    else $error("16-bit remaining count read not coherent");

  // a finite count stops the pin once the periods have run
  pin_idle_a: assert property (!mode_16bit[0] && !$past(chan_start[1]) &&
    $fell(|chan_rem[1]) |=> !waveform_pin[1])
    else $error("pin1 still active after its periods ran out");

endmodule : wg_timing_regs

//--- bench/testbench.sv
// self-checking bench for the pin waveform timing registers
`timescale 1ns/1ps
module testbench;
  import wg_pkg::*;
  localparam int IDLE_LIM = 3000;
  localparam int LIMIT = 60000;
  logic sys_clk;
  logic nrst;
  reg_req_t bus_req;
  logic [7:0] reg_rdata;
  logic [1:0] mode_16bit;
  logic [2:0][1:0][7:0] pair01_early_sub;
  logic [2:0][1:0][7:0] pair23_late_sub;
  logic [1:0][7:0] pair23_count;
  logic pair23_load;
  logic [3:0] waveform_pin;
  int fail_count;
  int checks;
  int cycles;

  wg_timing_regs DUT (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req),
    .reg_rdata(reg_rdata), .mode_16bit(mode_16bit),
    .pair01_early_sub(pair01_early_sub), .pair23_late_sub(pair23_late_sub),
    .pair23_count(pair23_count), .pair23_load(pair23_load),
    .waveform_pin(waveform_pin));

  // ==========================================================================
  // clock, watchdog and report
  // ==========================================================================
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // a hang counts as a mismatch and closes the run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic check_val(input logic [7:0] got, input logic [7:0] exp,
                           input string what);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask : check_val

  task automatic check_len(input int got, input int lo, input int hi,
                           input string what);
    checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[ERR] %0t %s: got %0d want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : check_len

  // ==========================================================================
  // bus and waveform helpers
  // ==========================================================================
  // an idle edge first, so wr never drops and rises in one time step
  task automatic bus_write(input logic [15:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    bus_req.addr = a;
    bus_req.wdata = d;
    bus_req.wr = 1'b1;
    @(negedge sys_clk);
    bus_req.wr = 1'b0;
  endtask : bus_write

  // read data holds until the next read, so it is taken a cycle late
  task automatic bus_read(input logic [15:0] a, output logic [7:0] d);
    bus_req.addr = a;
    bus_req.rd = 1'b1;
    @(negedge sys_clk);
    bus_req.rd = 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask : bus_read

  task automatic read_chk(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bus_read(a, d);
    check_val(d, exp, $sformatf("read %h", a));
  endtask : read_chk

  // run lengths of one pin, high first, until it idles low or maxseg runs
  task automatic capture(input int p, input int maxseg, output int q[$]);
    int n;
    int guard;
    logic lvl;
    q = {};
    n = 0;
    guard = 0;
    while (waveform_pin[p] !== 1'b1 && guard < 100) begin
      @(negedge sys_clk);
      guard++;
    end
    lvl = 1'b1;
    while (q.size() < maxseg && !(lvl == 1'b0 && n > IDLE_LIM)) begin
      @(negedge sys_clk);
      n++;
      if (waveform_pin[p] !== lvl) begin
        q.push_back(n);
        n = 0;
        lvl = ~lvl;
      end
    end
  endtask : capture

  // high in subperiods 1,3,5 so the fifth merges with the next first
  function automatic void build(input int t[5], input int n, output int q[$]);
    int c[5];
    q = {};
    for (int k = 0; k < 5; k++) c[k] = (t[k] + 1) * TICK_CYCLES;
    for (int i = 0; i < n; i++) begin
      if (i == 0) q.push_back(c[0]);
      q.push_back(c[1]);
      q.push_back(c[2]);
      q.push_back(c[3]);
      q.push_back((i == n - 1) ? c[4] : c[4] + c[0]);
    end
  endfunction : build

  // the first run may start part way through a tick
  task automatic check_wave(input int got[$], input int exp[$]);
    check_len(got.size(), exp.size(), exp.size(), "run count");
    for (int i = 0; i < exp.size() && i < got.size(); i++) begin
      check_len(got[i], (i == 0) ? exp[i] - TICK_CYCLES + 1 : exp[i], exp[i],
                $sformatf("run %0d", i));
    end
  endtask : check_wave

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic test_regs();
    for (int i = 0; i < NUM_REGS; i++) begin
      read_chk(REG_BASE + 16'(i), REG_RESET);
    end
    bus_write(16'h1090, 8'h5a);
    read_chk(16'h1090, UNMAPPED_READ);
    read_chk(16'h1085, UNMAPPED_READ);
    for (int i = 0; i < NUM_REGS; i++) begin
      if (i != IDX_PIN1_COUNT && i != IDX_PIN0_COUNT) begin
        bus_write(REG_BASE + 16'(i), 8'ha0 + 8'(i));
        read_chk(REG_BASE + 16'(i), 8'ha0 + 8'(i));
      end
    end
  endtask : test_regs

  task automatic test_pair01_8bit();
    int q0[$], q1[$], e0[$], e1[$];
    mode_16bit = 2'b00;
    pair01_early_sub = {8'h02, 8'h03, 8'h00, 8'h02, 8'h04, 8'h01};
    bus_write(ADDR_PIN0_FOURTH, 8'h01);
    bus_write(ADDR_PIN0_FIFTH, 8'h03);
    bus_write(ADDR_PIN1_FOURTH, 8'h02);
    bus_write(ADDR_PIN1_FIFTH, 8'h00);
    build('{1, 2, 3, 1, 3}, 2, e0);
    build('{4, 0, 2, 2, 0}, 1, e1);
    // captures wait for the first high run, so both starts are seen
    fork
      capture(0, 99, q0);
      capture(1, 99, q1);
      begin
        bus_write(ADDR_PIN1_COUNT, 8'h01);
        bus_write(ADDR_PIN0_COUNT, 8'h02);
        read_chk(ADDR_PIN0_COUNT, 8'h02);
        read_chk(ADDR_PIN1_COUNT, 8'h01);
      end
    join
    check_wave(q0, e0);
    check_wave(q1, e1);
    read_chk(ADDR_PIN0_COUNT, 8'h00);
    read_chk(ADDR_PIN1_COUNT, 8'h00);
  endtask : test_pair01_8bit

  task automatic test_pair01_16bit();
    int q0[$], e0[$];
    int hi;
    logic [7:0] d;
    hi = 0;
    mode_16bit = 2'b01;
    pair01_early_sub = {8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h01};
    bus_write(ADDR_PIN1_FOURTH, 8'h01);
    bus_write(ADDR_PIN0_FOURTH, 8'h00);
    bus_write(ADDR_PIN1_FIFTH, 8'h01);
    bus_write(ADDR_PIN0_FIFTH, 8'h02);
    bus_write(ADDR_PIN1_COUNT, 8'h00);
    bus_write(ADDR_PIN0_COUNT, 8'h02);
    build('{1, 0, 2, 256, 258}, 2, e0);
    fork
      capture(0, 99, q0);
      repeat (9000) begin
        @(negedge sys_clk);
        if (waveform_pin[1] !== 1'b0) hi++;
      end
    join
    check_wave(q0, e0);
    check_len(hi, 0, 0, "odd pin idle");
    pair01_early_sub = '0;
    for (int i = 0; i < 4; i++) bus_write(REG_BASE + 16'(i), 8'h00);
    bus_write(ADDR_PIN1_COUNT, 8'h01);
    bus_write(ADDR_PIN0_COUNT, 8'h00);
    read_chk(ADDR_PIN1_COUNT, 8'h01);
    repeat (120) @(negedge sys_clk);
    read_chk(ADDR_PIN0_COUNT, 8'h00);
    read_chk(ADDR_PIN1_COUNT, 8'h00);
    bus_read(ADDR_PIN0_COUNT, d);
    check_len(int'(d), 240, 254, "live low byte");
    mode_16bit = 2'b00;
    repeat (4) @(negedge sys_clk);
    check_val({4'h0, waveform_pin}, 8'h00, "stopped pins");
  endtask : test_pair01_16bit

  task automatic test_pair23();
    int q2[$], q3[$], e2[$], e3[$];
    bus_write(ADDR_PIN2_FIRST, 8'h03);
    bus_write(ADDR_PIN2_SECOND, 8'h01);
    bus_write(ADDR_PIN3_FIRST, 8'h00);
    bus_write(ADDR_PIN3_SECOND, 8'h02);
    pair23_late_sub = {8'h00, 8'h02, 8'h01, 8'h00, 8'h00, 8'h01};
    pair23_count = '0;
    pair23_load = 1'b1;
    @(negedge sys_clk);
    pair23_load = 1'b0;
    build('{3, 1, 1, 0, 2}, 3, e2);
    build('{0, 2, 0, 1, 0}, 3, e3);
    e2 = e2[0:10];
    e3 = e3[0:10];
    fork
      capture(2, 11, q2);
      capture(3, 11, q3);
    join
    check_wave(q2, e2);
    check_wave(q3, e3);
    mode_16bit = 2'b10;
    repeat (4) @(negedge sys_clk);
    check_val({4'h0, waveform_pin}, 8'h00, "stopped pins");
    bus_write(ADDR_PIN3_FIRST, 8'h01);
    bus_write(ADDR_PIN3_SECOND, 8'h00);
    pair23_count = {8'h00, 8'h01};
    pair23_load = 1'b1;
    @(negedge sys_clk);
    pair23_load = 1'b0;
    build('{259, 1, 1, 256, 2}, 1, e2);
    capture(2, 99, q2);
    check_wave(q2, e2);
    check_val({4'h0, waveform_pin}, 8'h00, "idle after run");
  endtask : test_pair23

  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    fail_count = 0;
    checks = 0;
    cycles = 0;
    nrst = 1'b0;
    bus_req = '0;
    mode_16bit = 2'b00;
    pair01_early_sub = '0;
    pair23_late_sub = '0;
    pair23_count = '0;
    pair23_load = 1'b0;
    repeat (10) @(negedge sys_clk);
    nrst = 1'b1;
    check_val({4'h0, waveform_pin}, 8'h00, "pins at reset");
    test_regs();
    test_pair01_8bit();
    test_pair01_16bit();
    test_pair23();
    print_verdict();
  end
endmodule : testbench
